//--- inc/adsq_map.svh
// Register offsets, field positions and reset values of the converter sequencer
`ifndef ADSQ_MAP_SVH
`define ADSQ_MAP_SVH

// Byte offsets on the register port
`define ADSQ_OFF_CLK 8'h00
`define ADSQ_OFF_MOD0 8'h04
`define ADSQ_OFF_MOD1 8'h08
`define ADSQ_OFF_MOD2 8'h0c
`define ADSQ_OFF_MOD3 8'h10
`define ADSQ_OFF_MOD4 8'h14
`define ADSQ_OFF_MOD5 8'h18
`define ADSQ_OFF_REG0 8'h30
`define ADSQ_OFF_REGSP 8'h60
`define ADSQ_OFF_CMP0 8'h64
`define ADSQ_OFF_CMP1 8'h68
`define ADSQ_REG_SPAN 8'h30

// Field positions
`define ADSQ_M0_START 0
`define ADSQ_M2_PRIO_START 5
`define ADSQ_M4_PRIO_SRC 7
`define ADSQ_M4_PRIO_PERMIT 6
`define ADSQ_M4_NORM_SRC 5
`define ADSQ_M4_NORM_PERMIT 4
`define ADSQ_MON_EN 0
`define ADSQ_MON_POL 5
`define ADSQ_VAL_LSB 6

// Reset values and codes
`define ADSQ_CLK_RST 3'h0
`define ADSQ_KEY_ARM 2'h2
`define ADSQ_KEY_FIRE 2'h1
`define ADSQ_SP_INDEX 4'hc
`define ADSQ_NO_INDEX 4'hf

`endif

//--- inc/adsq_pkg.sv
// Types shared by the converter sequencer and its bench
package adsq_pkg;

    // Register port request, one cycle per strobe
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } adsq_bus_req_t;

    // Command to the analog core
    typedef struct packed {
        logic start;
        logic abort;
        logic [3:0] channel;
    } adsq_conv_cmd_t;

    // Answer of the analog core
    typedef struct packed {
        logic done;
        logic [9:0] data;
    } adsq_conv_res_t;

    // One result register
    typedef struct packed {
        logic [9:0] value;
        logic overrun;
        logic stored;
    } adsq_slot_t;

    // Sequencer states
    typedef enum logic [2:0] {
        ADSQ_IDLE = 3'b001,
        ADSQ_NORM = 3'b010,
        ADSQ_PRIO = 3'b100
    } adsq_state_t;

endpackage

//--- hdl/adsq_top.sv
// Converter sequencer with priority pre-emption, result bank and monitors
//
// Operation
// - Bits 6 and 4 of trigger control permit hardware starts, priority and normal.
// - Bit 5 picks the falling trigger pin (0) or timer match (1) for normal.
// - Key 10 then 01 resets every register except the clock select.
// - Monitor 1 enable bit 0; polarity 0 means below threshold, 1 above.
// - Monitor source codes 0000-0111 pick result 0-7; 1xxx picks priority result.
// - Result value sits in bits 15-6; bits 31-16 and 5-2 read zero.
// - Overrun bit 1 sets when an unread result is overwritten; reading the result clears it.
// - Stored bit 0 sets on every store; reading the result clears it.
// - Priority result holds value in 15-6 with the same two flags.
// - Two mode bits: 00 fixed single, 01 scan single, 10 fixed/11 scan repeat.
// - Scan size picks a 4, 8 or 12 channel group; channel picks its end.
// - Single modes end with complete set, busy cleared, completion pulse.
// - Fixed repeat keeps busy; complete and pulse every 1, 4 or 8 results.
// - Scan repeat keeps busy; each finished pass sets complete and pulses.
// - Priority converts its own channel once, pulses, sets complete, clears busy.
// - Priority pre-empts normal work; a priority request while busy is dropped.
// - Each enabled monitor compares on every store to its source and pulses if the value passes its threshold.
// - Source 0 starts on a falling trigger pin edge, source 1 on timer match.
// - After the priority result is stored, normal work resumes at its channel.
// - Writing 1 to the start bit starts; it reads 0; software start stays valid.
`timescale 1ns/1ps
`include "adsq_map.svh"

module adsq_top #(
    parameter int NRES = 12
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire adsq_pkg::adsq_bus_req_t bus_req,
    output logic [31:0] rd_data,
    input wire adsq_pkg::adsq_conv_res_t conv_res,
    output adsq_pkg::adsq_conv_cmd_t conv_cmd,
    output logic [2:0] conversion_clock_select,
    output logic reference_enable,
    input wire logic external_trigger_input_n,
    input wire logic timer_match_normal,
    input wire logic timer_match_priority,
    output logic normal_done_irq,
    output logic priority_done_irq,
    output logic monitor0_irq,
    output logic monitor1_irq
);

    // Map a byte address to a result slot, or to no slot
    function automatic logic [3:0] res_index(input logic [7:0] a);
        logic [7:0] d;
        d = a - `ADSQ_OFF_REG0;
        if (a == `ADSQ_OFF_REGSP)
            return `ADSQ_SP_INDEX;
        if (a >= `ADSQ_OFF_REG0 && d < `ADSQ_REG_SPAN && d[1:0] == 2'h0)
            return d[5:2];
        return `ADSQ_NO_INDEX;
    endfunction

    // Does a monitor source code pick this slot
    function automatic logic src_hit(input logic [3:0] sel,
                                     input logic [3:0] idx);
        if (sel[3])
            return idx == `ADSQ_SP_INDEX;
        return idx == {1'b0, sel[2:0]};
    endfunction

    // First and last channel of a scan group, packed as {first, last}
    function automatic logic [7:0] scan_bounds(input logic [1:0] size,
                                               input logic [3:0] ch);
        case (size)
            2'h1: scan_bounds = {4'h0, 1'b0, ch[2:0]};
            2'h2: scan_bounds = ch[3] ? {4'h0, 2'b10, ch[1:0]}
                                      : {4'h0, 1'b0, ch[2:0]};
            default: scan_bounds = {1'b0, ch[2], 2'b00, 1'b0, ch[2:0]};
        endcase
    endfunction

    logic srst_reg;
    logic sreset;
    logic key_armed_reg;
    logic [4:0] mode0_reg;
    logic [7:0] mode1_reg;
    logic [3:0] prio_ch_reg;
    logic [5:0] mon_ctl_reg [2];
    logic [9:0] thr_reg [2];
    logic [3:0] trig_ctl_reg;
    logic [2:0] trig_sync_reg;
    logic trig_fall;
    logic norm_req_reg;
    logic prio_req_reg;
    adsq_pkg::adsq_state_t state_reg;
    logic [3:0] cur_ch_reg;
    logic [2:0] itm_cnt_reg;
    logic norm_busy_reg;
    logic prio_busy_reg;
    logic norm_cmpl_reg;
    logic prio_cmpl_reg;
    adsq_pkg::adsq_slot_t slot_reg [NRES + 1];
    logic [1:0] mon_irq_reg;
    logic wr_hit_mod0;
    logic rd_hit_mod0;
    logic rd_hit_mod2;
    logic [3:0] rd_idx;
    logic [7:0] bounds;
    logic last_ch;
    logic norm_done;
    logic norm_fire;
    logic norm_stop;
    logic st_v;
    logic [3:0] st_idx;
    logic [2:0] itm_top;

    // All checks below share the system clock and stand down in reset
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sreset);

    // Soft reset is a flop so it never glitches the register bank
    assign sreset = rst | srst_reg;
    assign wr_hit_mod0 = bus_req.wr && bus_req.addr == `ADSQ_OFF_MOD0;
    assign rd_hit_mod0 = bus_req.rd && bus_req.addr == `ADSQ_OFF_MOD0;
    assign rd_hit_mod2 = bus_req.rd && bus_req.addr == `ADSQ_OFF_MOD2;
    assign rd_idx = bus_req.rd ? res_index(bus_req.addr) : `ADSQ_NO_INDEX;
    assign trig_fall = trig_sync_reg[2] & ~trig_sync_reg[1];

    // Reset key sequence; any other write to the field disarms it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            srst_reg <= 1'b0;
            key_armed_reg <= 1'b0;
        end else begin
            srst_reg <= 1'b0;
            if (bus_req.wr && bus_req.addr == `ADSQ_OFF_MOD4) begin
                key_armed_reg <= bus_req.wdata[1:0] == `ADSQ_KEY_ARM;
                if (key_armed_reg && bus_req.wdata[1:0] == `ADSQ_KEY_FIRE)
                    srst_reg <= 1'b1;
            end
        end
    end

    // Clock select survives the soft reset
    always_ff @(posedge clk_sys) begin
        if (rst)
            conversion_clock_select <= `ADSQ_CLK_RST;
        else if (bus_req.wr && bus_req.addr == `ADSQ_OFF_CLK)
            conversion_clock_select <= bus_req.wdata[2:0];
    end

    // Writable configuration; only defined fields are stored
    always_ff @(posedge clk_sys) begin
        if (sreset) begin
            mode0_reg <= '0;
            mode1_reg <= '0;
            prio_ch_reg <= '0;
            trig_ctl_reg <= '0;
            mon_ctl_reg[0] <= '0;
            mon_ctl_reg[1] <= '0;
            thr_reg[0] <= '0;
            thr_reg[1] <= '0;
        end else if (bus_req.wr) begin
            case (bus_req.addr)
                `ADSQ_OFF_MOD0: mode0_reg <= bus_req.wdata[4:0];
                `ADSQ_OFF_MOD1: mode1_reg <= bus_req.wdata[7:0];
                `ADSQ_OFF_MOD2: prio_ch_reg <= bus_req.wdata[3:0];
                `ADSQ_OFF_MOD3: mon_ctl_reg[0] <= bus_req.wdata[5:0];
                `ADSQ_OFF_MOD4: trig_ctl_reg <= bus_req.wdata[7:4];
                `ADSQ_OFF_MOD5: mon_ctl_reg[1] <= bus_req.wdata[5:0];
                `ADSQ_OFF_CMP0: thr_reg[0] <= bus_req.wdata[15:6];
                `ADSQ_OFF_CMP1: thr_reg[1] <= bus_req.wdata[15:6];
                default: ;
            endcase
        end
    end

    // Trigger pin: two sync stages, the third stage only feeds the edge
    always_ff @(posedge clk_sys) begin
        if (rst)
            trig_sync_reg <= 3'h7;
        else
            trig_sync_reg <= {trig_sync_reg[1:0], external_trigger_input_n};
    end

    // Requests are latched one cycle so the mode written alongside applies
    always_ff @(posedge clk_sys) begin
        if (sreset) begin
            norm_req_reg <= 1'b0;
            prio_req_reg <= 1'b0;
        end else begin
            norm_req_reg <= (wr_hit_mod0 && bus_req.wdata[`ADSQ_M0_START]) ||
                (trig_ctl_reg[`ADSQ_M4_NORM_PERMIT - 4] &&
                 (trig_ctl_reg[`ADSQ_M4_NORM_SRC - 4] ? timer_match_normal
                                                      : trig_fall));
            prio_req_reg <= (bus_req.wr && bus_req.addr == `ADSQ_OFF_MOD2 &&
                             bus_req.wdata[`ADSQ_M2_PRIO_START]) ||
                (trig_ctl_reg[`ADSQ_M4_PRIO_PERMIT - 4] &&
                 (trig_ctl_reg[`ADSQ_M4_PRIO_SRC - 4] ? timer_match_priority
                                                      : trig_fall));
        end
    end

    // Completion decode of a normal result; REPEAT_IRQ_INTERVAL 11 is treated as every one
    always_comb begin
        bounds = scan_bounds(mode1_reg[5:4], mode1_reg[3:0]);
        last_ch = !mode0_reg[1] || cur_ch_reg == bounds[3:0];
        case (mode0_reg[4:3])
            2'h1: itm_top = 3'h3;
            2'h2: itm_top = 3'h7;
            default: itm_top = 3'h0;
        endcase
        norm_done = state_reg == adsq_pkg::ADSQ_NORM && conv_res.done &&
                    !prio_req_reg;
        norm_stop = norm_done && !mode0_reg[2] && last_ch;
        if (mode0_reg[2] && !mode0_reg[1])
            norm_fire = norm_done && itm_cnt_reg == itm_top;
        else
            norm_fire = norm_done && last_ch;
        st_v = norm_done ||
               (state_reg == adsq_pkg::ADSQ_PRIO && conv_res.done);
        if (state_reg == adsq_pkg::ADSQ_PRIO)
            st_idx = `ADSQ_SP_INDEX;
        else
            st_idx = mode0_reg[1] ? cur_ch_reg : 4'h0;
    end

    // Sequencer; a normal start while anything is busy is not taken
    always_ff @(posedge clk_sys) begin
        if (sreset) begin
            state_reg <= adsq_pkg::ADSQ_IDLE;
            cur_ch_reg <= '0;
            itm_cnt_reg <= '0;
            norm_busy_reg <= 1'b0;
            prio_busy_reg <= 1'b0;
            conv_cmd <= '0;
            normal_done_irq <= 1'b0;
            priority_done_irq <= 1'b0;
        end else begin
            conv_cmd.start <= 1'b0;
            conv_cmd.abort <= 1'b0;
            normal_done_irq <= norm_fire;
            priority_done_irq <= 1'b0;
            case (state_reg)
                adsq_pkg::ADSQ_IDLE: begin
                    if (prio_req_reg) begin
                        state_reg <= adsq_pkg::ADSQ_PRIO;
                        prio_busy_reg <= 1'b1;
                        conv_cmd.start <= 1'b1;
                        conv_cmd.channel <= prio_ch_reg;
                    end else if (norm_req_reg) begin
                        state_reg <= adsq_pkg::ADSQ_NORM;
                        norm_busy_reg <= 1'b1;
                        itm_cnt_reg <= '0;
                        cur_ch_reg <= mode0_reg[1] ? bounds[7:4]
                                                   : mode1_reg[3:0];
                        conv_cmd.start <= 1'b1;
                        conv_cmd.channel <= mode0_reg[1] ? bounds[7:4]
                                                         : mode1_reg[3:0];
                    end
                end
                adsq_pkg::ADSQ_NORM: begin
                    if (prio_req_reg) begin
                        // Abort the normal conversion, keep its channel
                        state_reg <= adsq_pkg::ADSQ_PRIO;
                        prio_busy_reg <= 1'b1;
                        conv_cmd.abort <= 1'b1;
                        conv_cmd.start <= 1'b1;
                        conv_cmd.channel <= prio_ch_reg;
                    end else if (norm_done) begin
                        itm_cnt_reg <= norm_fire ? 3'h0
                                                 : 3'(itm_cnt_reg + 3'h1);
                        if (norm_stop) begin
                            state_reg <= adsq_pkg::ADSQ_IDLE;
                            norm_busy_reg <= 1'b0;
                        end else begin
                            // Next channel, wrapping in the scan group
                            cur_ch_reg <= !mode0_reg[1] ? mode1_reg[3:0] :
                                last_ch ? bounds[7:4]
                                        : 4'(cur_ch_reg + 4'h1);
                            conv_cmd.start <= 1'b1;
                            conv_cmd.channel <= !mode0_reg[1] ?
                                mode1_reg[3:0] : last_ch ? bounds[7:4]
                                : 4'(cur_ch_reg + 4'h1);
                        end
                    end
                end
                adsq_pkg::ADSQ_PRIO: begin
                    if (conv_res.done) begin
                        prio_busy_reg <= 1'b0;
                        priority_done_irq <= 1'b1;
                        if (norm_busy_reg) begin
                            state_reg <= adsq_pkg::ADSQ_NORM;
                            conv_cmd.start <= 1'b1;
                            conv_cmd.channel <= cur_ch_reg;
                        end else begin
                            state_reg <= adsq_pkg::ADSQ_IDLE;
                        end
                    end
                end
                default: state_reg <= adsq_pkg::ADSQ_IDLE;
            endcase
        end
    end

    // Completion flags: a set in the same cycle as the clearing read wins
    always_ff @(posedge clk_sys) begin
        if (sreset) begin
            norm_cmpl_reg <= 1'b0;
            prio_cmpl_reg <= 1'b0;
        end else begin
            norm_cmpl_reg <= norm_fire | (norm_cmpl_reg & ~rd_hit_mod0);
            prio_cmpl_reg <= (state_reg == adsq_pkg::ADSQ_PRIO &&
                conv_res.done) | (prio_cmpl_reg & ~rd_hit_mod2);
        end
    end

    // Result bank, normal slots and the priority slot at the top
    genvar k;
    generate
        for (k = 0; k <= NRES; k++) begin : g_slot
            always_ff @(posedge clk_sys) begin
                if (sreset) begin
                    slot_reg[k] <= '0;
                end else if (st_v && st_idx == 4'(k)) begin
                    slot_reg[k].value <= conv_res.data;
                    slot_reg[k].stored <= 1'b1;
                    slot_reg[k].overrun <= slot_reg[k].stored |
                        (slot_reg[k].overrun & (rd_idx != 4'(k)));
                end else if (rd_idx == 4'(k)) begin
                    slot_reg[k].stored <= 1'b0;
                    slot_reg[k].overrun <= 1'b0;
                end
            end
        end
        // Monitors compare the incoming value, so no stale-data window
        for (k = 0; k < 2; k++) begin : g_mon
            always_ff @(posedge clk_sys) begin
                if (sreset)
                    mon_irq_reg[k] <= 1'b0;
                else
                    mon_irq_reg[k] <= st_v && mon_ctl_reg[k][`ADSQ_MON_EN] &&
                        src_hit(mon_ctl_reg[k][4:1], st_idx) &&
                        (mon_ctl_reg[k][`ADSQ_MON_POL] ?
                         conv_res.data > thr_reg[k] :
                         conv_res.data < thr_reg[k]);
            end
        end
    endgenerate

    assign monitor0_irq = mon_irq_reg[0];
    assign monitor1_irq = mon_irq_reg[1];

    // Reference enable follows its control bit
    always_ff @(posedge clk_sys) begin
        if (sreset)
            reference_enable <= 1'b0;
        else
            reference_enable <= mode1_reg[7];
    end

    // Read data one cycle after the strobe; unmapped and idle read zero
    always_ff @(posedge clk_sys) begin
        if (sreset) begin
            rd_data <= '0;
        end else begin
            rd_data <= '0;
            if (rd_idx != `ADSQ_NO_INDEX)
                rd_data <= {16'h0, slot_reg[rd_idx].value, 4'h0,
                            slot_reg[rd_idx].overrun,
                            slot_reg[rd_idx].stored};
            else if (bus_req.rd)
                case (bus_req.addr)
                    `ADSQ_OFF_CLK: rd_data <= {29'h0, conversion_clock_select};
                    `ADSQ_OFF_MOD0: rd_data <= {24'h0, norm_cmpl_reg,
                        norm_busy_reg, 1'b0, mode0_reg[4:1], 1'b0};
                    `ADSQ_OFF_MOD1: rd_data <= {24'h0, mode1_reg};
                    `ADSQ_OFF_MOD2: rd_data <= {24'h0, prio_cmpl_reg,
                        prio_busy_reg, 2'h0, prio_ch_reg};
                    `ADSQ_OFF_MOD3: rd_data <= {26'h0, mon_ctl_reg[0]};
                    `ADSQ_OFF_MOD4: rd_data <= {24'h0, trig_ctl_reg, 4'h0};
                    `ADSQ_OFF_MOD5: rd_data <= {26'h0, mon_ctl_reg[1]};
                    `ADSQ_OFF_CMP0: rd_data <= {16'h0, thr_reg[0], 6'h0};
                    `ADSQ_OFF_CMP1: rd_data <= {16'h0, thr_reg[1], 6'h0};
                    default: rd_data <= '0;
                endcase
        end
    end

    // Checks on the sequencer and flags

    property p_irq_pulse;
        normal_done_irq |=> !normal_done_irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("normal completion pulse longer than one cycle");

    property p_single_end;
        norm_stop |=> !norm_busy_reg && norm_cmpl_reg && normal_done_irq;
    endproperty
    a_single_end: assert property (p_single_end)
        else $error("single mode end did not set flags together");

    property p_repeat_busy;
        norm_done && mode0_reg[2] |=> norm_busy_reg;
    endproperty
    a_repeat_busy: assert property (p_repeat_busy)
        else $error("busy dropped in repeat mode");

    property p_preempt;
        state_reg == adsq_pkg::ADSQ_NORM && prio_req_reg |=>
            conv_cmd.abort && conv_cmd.start &&
            conv_cmd.channel == $past(prio_ch_reg) && prio_busy_reg;
    endproperty
    a_preempt: assert property (p_preempt)
        else $error("priority request did not pre-empt normal work");

    property p_prio_ignored;
        state_reg == adsq_pkg::ADSQ_PRIO && !conv_res.done |=>
            !conv_cmd.start && state_reg == adsq_pkg::ADSQ_PRIO;
    endproperty
    a_prio_ignored: assert property (p_prio_ignored)
        else $error("request disturbed a running priority conversion");

    property p_resume;
        state_reg == adsq_pkg::ADSQ_PRIO && conv_res.done && norm_busy_reg
            |=> conv_cmd.start && conv_cmd.channel == $past(cur_ch_reg);
    endproperty
    a_resume: assert property (p_resume)
        else $error("normal work did not resume at its channel");

    property p_prio_done;
        state_reg == adsq_pkg::ADSQ_PRIO && conv_res.done |=>
            (priority_done_irq && prio_cmpl_reg && !prio_busy_reg &&
             slot_reg[NRES].stored) ##1 !priority_done_irq;
    endproperty
    a_prio_done: assert property (p_prio_done)
        else $error("priority completion effects wrong");

    property p_store_flags;
        st_v && st_idx != `ADSQ_SP_INDEX && slot_reg[st_idx].stored |=>
            slot_reg[$past(st_idx)].overrun &&
            slot_reg[$past(st_idx)].stored;
    endproperty
    a_store_flags: assert property (p_store_flags)
        else $error("overwrite of unread result did not flag overrun");

    property p_start_reads_zero;
        rd_hit_mod0 |=> rd_data[`ADSQ_M0_START] == 1'b0 &&
            rd_data[31:8] == 24'h0;
    endproperty
    a_start_reads_zero: assert property (p_start_reads_zero)
        else $error("start bit or reserved bits read nonzero");

    property p_hw_start;
        trig_fall && trig_ctl_reg[0] && !trig_ctl_reg[1] &&
        state_reg == adsq_pkg::ADSQ_IDLE && !prio_req_reg &&
        !(trig_ctl_reg[2] && !trig_ctl_reg[3]) ##1 !prio_req_reg
            |=> norm_busy_reg && conv_cmd.start;
    endproperty
    a_hw_start: assert property (p_hw_start)
        else $error("falling trigger edge did not start conversion");

    c_preempt: cover property (state_reg == adsq_pkg::ADSQ_NORM &&
                               prio_req_reg);
    c_scan_pass: cover property (norm_fire && mode0_reg[1] && mode0_reg[2]);
    c_monitor: cover property (monitor0_irq || monitor1_irq);
    c_soft_reset: cover property (srst_reg);

endmodule // adsq_top

//--- testbench/adsq_core_model.sv
// Behavioural analog core answering each start after a fixed delay
`timescale 1ns/1ps
module adsq_core_model #(
    parameter int DLY = 20
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire adsq_pkg::adsq_conv_cmd_t conv_cmd,
    output adsq_pkg::adsq_conv_res_t conv_res
);
    int cnt;
    logic [3:0] ch;
    // A start (abort rides with it) restarts the count; data churns off done
    always @(posedge clk_sys) begin
        conv_res.done <= 1'b0;
        conv_res.data <= ~conv_res.data;
        if (rst) begin
            cnt <= 0;
            conv_res.data <= 10'h155;
        end else if (conv_cmd.start) begin
            cnt <= DLY;
            ch <= conv_cmd.channel;
        end else if (cnt == 1) begin
            cnt <= 0;
            conv_res <= {1'b1, ch, 6'h2a}; // Value tells the channel apart
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule // adsq_core_model

//--- testbench/adsq_top_bench.sv
// Self-checking bench of the converter sequencer
`timescale 1ns/1ps
module adsq_top_bench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    adsq_pkg::adsq_bus_req_t bus_req = '0;
    logic [31:0] rd_data;
    adsq_pkg::adsq_conv_res_t conv_res;
    adsq_pkg::adsq_conv_cmd_t conv_cmd;
    logic trg_n = 1'b1;
    logic tm_n = 1'b0;
    logic tm_p = 1'b0;
    logic ref_en;
    logic [2:0] clk_sel;
    logic [3:0] irq;
    int cnt [4] = '{0, 0, 0, 0};
    int fails = 0;
    int comparisons = 0;
    logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h64, 8'h14,
        8'h2c};
    logic [31:0] rw [8] = '{'1, 32'h18, 32'hff, 32'hf, '1, '1, '1, '1};
    logic [31:0] re [8] = '{32'h7, 32'h18, 32'hff, 32'hf, 32'h3f, 32'hffc0,
        32'hf0, 32'h0};
    always #12.5 clk_sys = ~clk_sys;
    adsq_top u_dut (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req),
        .rd_data(rd_data), .conv_res(conv_res), .conv_cmd(conv_cmd),
        .conversion_clock_select(clk_sel), .reference_enable(ref_en),
        .external_trigger_input_n(trg_n), .timer_match_normal(tm_n),
        .timer_match_priority(tm_p), .normal_done_irq(irq[0]),
        .priority_done_irq(irq[1]), .monitor0_irq(irq[2]),
        .monitor1_irq(irq[3]));
    adsq_core_model u_core (.clk_sys(clk_sys), .rst(rst),
        .conv_cmd(conv_cmd), .conv_res(conv_res));
    // Tally of pulses on each interrupt output
    always @(posedge clk_sys) begin
        for (int i = 0; i < 4; i++) begin
            if (irq[i] === 1'b1) cnt[i]++;
        end
    end
    task automatic end_sim();
        $display("mismatches %0d of %0d checks", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        comparisons++;
        if (got !== e) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, got, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        bus_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1 chk(rd_data, e);
    endtask
    task automatic wait_irq(input int i, input int n);
        for (int k = 0; k < 300 && cnt[i] < n; k++) @(posedge clk_sys);
        if (cnt[i] < n) begin
            fails++;
            $display("wrong value at %0t: interrupt never came", $time);
            end_sim();
        end
        repeat (2) @(posedge clk_sys);
    endtask
    // One-cycle timer match pulse, priority or normal
    task automatic tick(input bit prio);
        @(posedge clk_sys);
        if (prio) tm_p <= 1'b1;
        else tm_n <= 1'b1;
        @(posedge clk_sys);
        tm_n <= 1'b0;
        tm_p <= 1'b0;
    endtask
    // Register rows first, then the sequencing cases
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            wr(ra[i], rw[i]);
            rd(ra[i], re[i]);
        end
        wr(8'h14, 32'h2);
        wr(8'h14, 32'h1);
        repeat (3) @(posedge clk_sys);
        rd(8'h08, 32'h0);
        rd(8'h00, 32'h7);
        chk({29'h0, clk_sel}, 32'h7);
        wr(8'h08, 32'h83);
        repeat (120) @(posedge clk_sys);
        chk({31'h0, ref_en}, 32'h1);
        wr(8'h04, 32'h1);
        wait_irq(0, 1);
        rd(8'h04, 32'h80);
        rd(8'h04, 32'h0);
        wr(8'h04, 32'h1);
        wait_irq(0, 2);
        rd(8'h30, 32'h3a83);
        rd(8'h30, 32'h3a80);
        wr(8'h68, 32'h0);
        wr(8'h18, 32'h21);
        wr(8'h04, 32'h1);
        wait_irq(0, 3);
        wr(8'h18, 32'h0);
        wr(8'h18, 32'h1);
        wr(8'h04, 32'h1);
        wait_irq(0, 4);
        chk(32'(cnt[3]), 32'h1);
        wr(8'h04, 32'h3);
        wait_irq(0, 5);
        rd(8'h38, 32'h2a81);
        rd(8'h30, 32'h0a83);
        wr(8'h04, 32'h1);
        repeat (3) @(posedge clk_sys);
        wr(8'h0c, 32'h25);
        wr(8'h0c, 32'h27);
        wait_irq(1, 1);
        rd(8'h60, 32'h5a81);
        wait_irq(0, 6);
        rd(8'h30, 32'h3a81);
        wr(8'h14, 32'h30);
        tick(1'b0);
        wait_irq(0, 7);
        wr(8'h14, 32'h10);
        trg_n <= 1'b0;
        wait_irq(0, 8);
        wr(8'h10, 32'h31);
        wr(8'h14, 32'hc0);
        tick(1'b1);
        wait_irq(1, 2);
        wr(8'h14, 32'h0);
        trg_n <= 1'b1;
        tick(1'b0);
        repeat (60) @(posedge clk_sys);
        chk(32'(cnt[0]), 32'h8);
        chk(32'(cnt[2]), 32'h1);
        end_sim();
    end
endmodule // adsq_top_bench
